// ---- include/nfa_pkg.sv ----
// constants, enums and carrier structs for the number format arithmetic unit
// assumes a single clock domain and an axi4-lite master with 32-bit data
package nfa_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPA = 8'h04;
  localparam logic [7:0] ADDR_OPB = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_ACC = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0fff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int ST_W = 6;
  // integer width groups, in bits
  localparam int W_SIXTEEN = 16;
  localparam int W_EIGHT = 8;
  localparam int W_SEVEN = 7;
  localparam int W_SIX = 6;
  localparam int W_FOUR = 4;
  localparam int W_THREE = 3;
  // float formats: total width, exponent width, bias
  localparam int F24_TOTAL = 24;
  localparam int F24_EXP = 8;
  localparam int HALF_TOTAL = 16;
  localparam int HALF_EXP = 5;
  localparam int BF_TOTAL = 16;
  localparam int BF_EXP = 8;
  localparam int BIAS_E8 = 127;
  localparam int BIAS_E5 = 15;
  // internal datapath: 16-bit significand, 34-bit normalising window
  localparam int INT_P = 16;
  localparam int NORM_W = 34;
  localparam logic signed [10:0] ZERO_EXP = -11'sd512;

  typedef enum logic [2:0] {
    width_group_sixteen = 3'h0,
    width_group_eight = 3'h1,
    width_group_seven = 3'h2,
    width_group_six = 3'h3,
    width_group_four = 3'h4,
    width_group_three = 3'h5
  } nfa_group_e;
  typedef enum logic [1:0] {
    int_twos_comp = 2'h0,
    int_unsigned = 2'h1,
    int_sign_mag = 2'h2
  } nfa_intfmt_e;
  typedef enum logic [1:0] {
    float24_e8 = 2'h0,
    half_float_e5 = 2'h1,
    brain_float_e8 = 2'h2
  } nfa_fpfmt_e;
  typedef enum logic [1:0] {
    op_mul = 2'h0,
    op_add = 2'h1,
    op_mac = 2'h2
  } nfa_op_e;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [1:0] op;
    logic isFloat;
    logic [1:0] fpOut;
    logic [1:0] fpIn;
    logic [1:0] intFmt;
    logic [2:0] group;
  } nfa_ctrl_s;
  typedef struct packed {
    logic sign;
    logic zero;
    logic inf;
    logic signed [10:0] exp;
    logic [15:0] mant;
  } nfa_unp_s;
  typedef struct packed {
    logic [23:0] word;
    logic ovf;
    logic unf;
    logic inv;
    logic inf;
    logic zero;
  } nfa_rnd_s;
endpackage

// ---- design/nfa_number_format_arith.sv ----
// number format arithmetic unit: integer and float multiply, add and
// multiply-accumulate behind an axi4-lite register slave
// assumes a synchronous active-low reset and one 40 MHz clock; the master
// keeps at most one write and one read outstanding
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
module nfa_number_format_arith (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // operand width of a group
  function automatic int intWidth(input logic [2:0] grp);
    case (grp)
      nfa_pkg::width_group_eight: return nfa_pkg::W_EIGHT;
      nfa_pkg::width_group_seven: return nfa_pkg::W_SEVEN;
      nfa_pkg::width_group_six: return nfa_pkg::W_SIX;
      nfa_pkg::width_group_four: return nfa_pkg::W_FOUR;
      nfa_pkg::width_group_three: return nfa_pkg::W_THREE;
      default: return nfa_pkg::W_SIXTEEN;
    endcase
  endfunction

  // bits above the group width are ignored
  function automatic logic signed [17:0] intDecode(
    input logic [31:0] raw,
    input logic [2:0] grp,
    input logic [1:0] fmt
  );
    int w;
    logic [17:0] mag;
    logic sgn;
    w = intWidth(grp);
    mag = 18'(raw & ((32'h1 << w) - 32'h1));
    sgn = raw[w-1];
    case (fmt)
      nfa_pkg::int_unsigned: return signed'(mag);
      nfa_pkg::int_sign_mag:
      begin
        // both zero encodings collapse to the same value
        mag = mag & 18'((32'h1 << (w - 1)) - 32'h1);
        return sgn ? -signed'(mag) : signed'(mag);
      end
      default: return sgn ? signed'(mag) - signed'(18'(32'h1 << w)) : signed'(mag);
    endcase
  endfunction

  // float format geometry
  function automatic int fpTotal(input logic [1:0] fmt);
    case (fmt)
      nfa_pkg::half_float_e5: return nfa_pkg::HALF_TOTAL;
      nfa_pkg::brain_float_e8: return nfa_pkg::BF_TOTAL;
      default: return nfa_pkg::F24_TOTAL;
    endcase
  endfunction

  function automatic int fpExpW(input logic [1:0] fmt);
    case (fmt)
      nfa_pkg::half_float_e5: return nfa_pkg::HALF_EXP;
      nfa_pkg::brain_float_e8: return nfa_pkg::BF_EXP;
      default: return nfa_pkg::F24_EXP;
    endcase
  endfunction

  function automatic int fpBias(input logic [1:0] fmt);
    if (fmt == nfa_pkg::half_float_e5)
    begin
      return nfa_pkg::BIAS_E5;
    end
    return nfa_pkg::BIAS_E8;
  endfunction

  // split a word of any format into sign, true exponent, 16-bit significand
  function automatic nfa_pkg::nfa_unp_s fpUnpack(input logic [31:0] raw, input logic [1:0] fmt);
    int tw;
    int ew;
    int p;
    logic [7:0] e;
    logic [14:0] m;
    nfa_pkg::nfa_unp_s u;
    tw = fpTotal(fmt);
    ew = fpExpW(fmt);
    p = tw - ew;
    e = 8'((raw >> (p - 1)) & ((32'h1 << ew) - 32'h1));
    m = 15'(raw & ((32'h1 << (p - 1)) - 32'h1));
    u.sign = raw[tw-1];
    u.inf = (32'(e) == (32'h1 << ew) - 32'h1);
    // subnormal inputs have a zero field and so read as zero
    u.zero = (e == 8'h00);
    u.exp = u.zero ? nfa_pkg::ZERO_EXP : 11'(int'(e) - fpBias(fmt));
    u.mant = u.zero ? 16'h0000 : 16'((32'(m) | (32'h1 << (p - 1))) << (nfa_pkg::INT_P - p));
    return u;
  endfunction

  // normalise, round and pack; the top bit of val stands for 2^expTop
  function automatic nfa_pkg::nfa_rnd_s roundPack(
    input logic sign,
    input logic signed [10:0] expTop,
    input logic [33:0] val,
    input logic [1:0] fmt,
    input logic forceInf,
    input logic forceZero
  );
    int lz;
    int tw;
    int ew;
    int p;
    int be;
    logic [33:0] nv;
    logic [33:0] rem;
    logic [33:0] half;
    logic [16:0] kept;
    logic up;
    nfa_pkg::nfa_rnd_s r;
    r = '0;
    tw = fpTotal(fmt);
    ew = fpExpW(fmt);
    p = tw - ew;
    lz = 0;
    for (int i = 0; i < nfa_pkg::NORM_W; i++)
    begin
      if (val[i])
      begin
        lz = nfa_pkg::NORM_W - 1 - i;
      end
    end
    nv = val << lz;
    rem = nv & 34'((64'h1 << (nfa_pkg::NORM_W - p)) - 64'h1);
    half = 34'(64'h1 << (nfa_pkg::NORM_W - p - 1));
    kept = 17'(nv >> (nfa_pkg::NORM_W - p));
    up = (rem > half) || ((rem == half) && kept[0]);
    kept = kept + 17'(up);
    be = int'(expTop) - lz + fpBias(fmt);
    // rounding carried out of the significand
    if (kept[p])
    begin
      kept = kept >> 1;
      be = be + 1;
    end
    if (forceInf || (!forceZero && val != '0 && be >= (1 << ew) - 1))
    begin
      r.ovf = !forceInf;
      r.inf = 1'b1;
      // canonical infinity: mantissa field cleared
      r.word = 24'((32'(sign) << (tw - 1)) | (((32'h1 << ew) - 32'h1) << (p - 1)));
    end
    else if (forceZero || val == '0 || be <= 0)
    begin
      r.unf = !forceZero && val != '0;
      r.zero = 1'b1;
      r.word = 24'(32'(sign) << (tw - 1));
    end
    else
    begin
      r.word = 24'((32'(sign) << (tw - 1)) | (32'(be) << (p - 1))
        | (32'(kept) & ((32'h1 << (p - 1)) - 32'h1)));
    end
    return r;
  endfunction

  // float24_e8 product; inf times zero is invalid and comes out as infinity
  function automatic nfa_pkg::nfa_rnd_s fpMul(input nfa_pkg::nfa_unp_s a, input nfa_pkg::nfa_unp_s b);
    logic [31:0] prod;
    nfa_pkg::nfa_rnd_s r;
    prod = a.mant * b.mant;
    r = roundPack(a.sign ^ b.sign, 11'(a.exp + b.exp + 11'sd1), {prod, 2'b00},
      nfa_pkg::float24_e8, a.inf || b.inf, a.zero || b.zero);
    r.inv = (a.inf && b.zero) || (a.zero && b.inf);
    return r;
  endfunction

  // float24_e8 sum; bits shifted off the smaller operand fold into a sticky bit
  function automatic nfa_pkg::nfa_rnd_s fpAdd(input nfa_pkg::nfa_unp_s a, input nfa_pkg::nfa_unp_s b);
    nfa_pkg::nfa_unp_s x;
    nfa_pkg::nfa_unp_s y;
    int d;
    logic [33:0] bx;
    logic [33:0] by;
    logic [33:0] sx;
    logic [33:0] sum;
    logic stk;
    logic sgn;
    nfa_pkg::nfa_rnd_s r;
    if ((a.exp < b.exp) || ((a.exp == b.exp) && (a.mant < b.mant)))
    begin
      x = b;
      y = a;
    end
    else
    begin
      x = a;
      y = b;
    end
    d = int'(x.exp) - int'(y.exp);
    bx = {1'b0, x.mant, 17'h00000};
    by = {1'b0, y.mant, 17'h00000};
    if (d >= nfa_pkg::NORM_W)
    begin
      sx = '0;
      stk = |by;
    end
    else
    begin
      sx = by >> d;
      stk = |(by & 34'((64'h1 << d) - 64'h1));
    end
    sum = (x.sign == y.sign) ? ((bx + sx) | 34'(stk)) : ((bx - sx - 34'(stk)) | 34'(stk));
    // exact cancellation gives +0 unless both inputs were -0
    sgn = (sum == '0) ? (a.sign & b.sign) : x.sign;
    r = roundPack(sgn, 11'(x.exp + 11'sd1), sum, nfa_pkg::float24_e8,
      x.inf || y.inf, 1'b0);
    r.inv = x.inf && y.inf && (x.sign != y.sign);
    return r;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] mergeStrb(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      nfa_pkg::ADDR_CTRL, nfa_pkg::ADDR_OPA, nfa_pkg::ADDR_OPB, nfa_pkg::ADDR_CMD,
      nfa_pkg::ADDR_RESULT, nfa_pkg::ADDR_STATUS, nfa_pkg::ADDR_ACC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic awreadyFf;
  logic wreadyFf;
  logic bvalidFf;
  logic [1:0] brespFf;
  logic arreadyFf;
  logic rvalidFf;
  logic [1:0] rrespFf;
  logic [31:0] rdataFf;
  logic [7:0] awAddrFf;
  logic [31:0] wDataFf;
  logic [3:0] wStrbFf;
  logic [31:0] ctrlFf;
  logic [31:0] opAFf;
  logic [31:0] opBFf;
  logic [31:0] resultFf;
  logic [31:0] accFf;
  logic [nfa_pkg::ST_W-1:0] statusFf;
  logic startFf;
  logic clearFf;
  logic doWrite;
  logic [31:0] nxt_rdata;
  logic [31:0] nxt_result;
  logic [nfa_pkg::ST_W-1:0] nxt_status;
  nfa_pkg::nfa_ctrl_s ctrl;
  nfa_pkg::nfa_unp_s unpA;
  nfa_pkg::nfa_unp_s unpB;
  nfa_pkg::nfa_unp_s unpAcc;
  nfa_pkg::nfa_unp_s unpMul;
  nfa_pkg::nfa_unp_s unpRes;
  nfa_pkg::nfa_rnd_s mulR;
  nfa_pkg::nfa_rnd_s fpRes;
  nfa_pkg::nfa_rnd_s outR;
  logic signed [17:0] intA;
  logic signed [17:0] intB;
  logic signed [35:0] intProd;

  assign ctrl = nfa_pkg::nfa_ctrl_s'(ctrlFf);
  assign doWrite = !awreadyFf && !wreadyFf && !bvalidFf;

  // write address and data are taken independently, then answered together
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      awreadyFf <= 1'b1;
      wreadyFf <= 1'b1;
      bvalidFf <= 1'b0;
      brespFf <= nfa_pkg::RESP_OKAY;
      awAddrFf <= 8'h00;
      wDataFf <= 32'h0000_0000;
      wStrbFf <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awreadyFf)
      begin
        awreadyFf <= 1'b0;
        awAddrFf <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wreadyFf)
      begin
        wreadyFf <= 1'b0;
        wDataFf <= s_axi_wdata;
        wStrbFf <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        bvalidFf <= 1'b1;
        brespFf <= isMapped(awAddrFf) ? nfa_pkg::RESP_OKAY : nfa_pkg::RESP_SLVERR;
      end
      if (bvalidFf && s_axi_bready)
      begin
        bvalidFf <= 1'b0;
        awreadyFf <= 1'b1;
        wreadyFf <= 1'b1;
      end
    end
  end

  // software registers; reserved control bits stay zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrlFf <= nfa_pkg::CTRL_RESET;
      opAFf <= 32'h0000_0000;
      opBFf <= 32'h0000_0000;
      startFf <= 1'b0;
      clearFf <= 1'b0;
    end
    else
    begin
      startFf <= 1'b0;
      clearFf <= 1'b0;
      if (doWrite)
      begin
        case (awAddrFf)
          nfa_pkg::ADDR_CTRL: ctrlFf <= mergeStrb(ctrlFf, wDataFf, wStrbFf) & nfa_pkg::CTRL_WMASK;
          nfa_pkg::ADDR_OPA: opAFf <= mergeStrb(opAFf, wDataFf, wStrbFf);
          nfa_pkg::ADDR_OPB: opBFf <= mergeStrb(opBFf, wDataFf, wStrbFf);
          nfa_pkg::ADDR_CMD:
          begin
            startFf <= wStrbFf[0] && wDataFf[nfa_pkg::CMD_START_BIT];
            clearFf <= wStrbFf[0] && wDataFf[nfa_pkg::CMD_CLEAR_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // arithmetic; one long combinational path, timed for the slow clock
  always_comb
  begin
    unpA = fpUnpack(opAFf, ctrl.fpIn);
    unpB = fpUnpack(opBFf, ctrl.fpIn);
    unpAcc = fpUnpack(accFf, nfa_pkg::float24_e8);
    mulR = fpMul(unpA, unpB);
    unpMul = fpUnpack({8'h00, mulR.word}, nfa_pkg::float24_e8);
    case (ctrl.op)
      nfa_pkg::op_add: fpRes = fpAdd(unpA, unpB);
      nfa_pkg::op_mac:
      begin
        // product is rounded to float24_e8 before it meets the accumulator
        fpRes = fpAdd(unpAcc, unpMul);
        fpRes.ovf = fpRes.ovf | mulR.ovf;
        fpRes.unf = fpRes.unf | mulR.unf;
        fpRes.inv = fpRes.inv | mulR.inv;
      end
      default: fpRes = mulR;
    endcase
    // second rounding to the output format; identity for float24_e8
    unpRes = fpUnpack({8'h00, fpRes.word}, nfa_pkg::float24_e8);
    outR = roundPack(unpRes.sign, unpRes.exp, {unpRes.mant, 18'h00000}, ctrl.fpOut,
      unpRes.inf, unpRes.zero);
    intA = intDecode(opAFf, ctrl.group, ctrl.intFmt);
    intB = intDecode(opBFf, ctrl.group, ctrl.intFmt);
    intProd = intA * intB;
    if (ctrl.isFloat)
    begin
      nxt_result = {8'h00, outR.word};
      nxt_status = {1'b1, outR.zero, outR.inf, fpRes.inv,
        fpRes.unf | outR.unf, fpRes.ovf | outR.ovf};
    end
    else
    begin
      case (ctrl.op)
        nfa_pkg::op_add: nxt_result = 32'(intA + intB);
        nfa_pkg::op_mac: nxt_result = accFf + intProd[31:0];
        default: nxt_result = intProd[31:0];
      endcase
      nxt_status = {1'b1, nxt_result == 32'h0000_0000, 4'h0};
    end
  end

  // result and status update on a start command, the accumulator only for op_mac; a clear in the same cycle wins over the start
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      resultFf <= 32'h0000_0000;
      statusFf <= '0;
      accFf <= 32'h0000_0000;
    end
    else if (clearFf)
    begin
      accFf <= 32'h0000_0000;
    end
    else if (startFf)
    begin
      resultFf <= nxt_result;
      statusFf <= nxt_status;
      if (ctrl.op == nfa_pkg::op_mac)
      begin
        // float accumulator keeps float24_e8 precision, not the output format
        accFf <= ctrl.isFloat ? {8'h00, fpRes.word} : nxt_result;
      end
    end
  end

  // read data selection; unmapped addresses read zero
  always_comb
  begin
    case (s_axi_araddr)
      nfa_pkg::ADDR_CTRL: nxt_rdata = ctrlFf;
      nfa_pkg::ADDR_OPA: nxt_rdata = opAFf;
      nfa_pkg::ADDR_OPB: nxt_rdata = opBFf;
      nfa_pkg::ADDR_RESULT: nxt_rdata = resultFf;
      nfa_pkg::ADDR_STATUS: nxt_rdata = 32'(statusFf);
      nfa_pkg::ADDR_ACC: nxt_rdata = accFf;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read channel: one read in flight
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      arreadyFf <= 1'b1;
      rvalidFf <= 1'b0;
      rrespFf <= nfa_pkg::RESP_OKAY;
      rdataFf <= 32'h0000_0000;
    end
    else if (s_axi_arvalid && arreadyFf)
    begin
      arreadyFf <= 1'b0;
      rvalidFf <= 1'b1;
      rdataFf <= nxt_rdata;
      rrespFf <= isMapped(s_axi_araddr) ? nfa_pkg::RESP_OKAY : nfa_pkg::RESP_SLVERR;
    end
    else if (rvalidFf && s_axi_rready)
    begin
      rvalidFf <= 1'b0;
      arreadyFf <= 1'b1;
    end
  end

  assign s_axi_awready = awreadyFf;
  assign s_axi_wready = wreadyFf;
  assign s_axi_bvalid = bvalidFf;
  assign s_axi_bresp = brespFf;
  assign s_axi_arready = arreadyFf;
  assign s_axi_rvalid = rvalidFf;
  assign s_axi_rresp = rrespFf;
  assign s_axi_rdata = rdataFf;

endmodule

// ---- tb/nfa_number_format_arith_sva.sv ----
// handshake checker for the number format arithmetic unit
// assumes it is bound to nfa_number_format_arith and sees only its ports
module nfa_number_format_arith_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // one clock domain, so one default clocking and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // answers stand until taken, payload frozen
  chk_b_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed early");
  chk_r_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))
    else $error("read answer dropped or changed early");
  // latency of each answer after the take
  chk_read_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one edge after address take");
  chk_write_latency:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid && !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer not two edges after joint take");
  // only one transfer in flight per direction
  chk_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_aw_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  // ready comes back one edge after the handshake
  chk_b_release:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
      && s_axi_wready)
    else $error("write channel not idle after answer");
  chk_r_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not idle after answer");
  // an error read carries no stale data
  chk_slverr_data:
    assert property (s_axi_rvalid && s_axi_rresp == nfa_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned nonzero data");
endmodule

bind nfa_number_format_arith nfa_number_format_arith_sva u_sva (
  .clk(clk),
  .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// ---- tb/nfa_number_format_arith_test.sv ----
// self-checking bench for the number format arithmetic unit
// assumes the handed-over register map and bus timing; bench is the bus master
module nfa_number_format_arith_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic [31:0] rdData;
  logic [1:0] rsp;
  int errCount = 0;
  int testsRun = 0;
  // when set, bready/rready rise only after the answer is seen, so it must stand
  logic slowAns = 1'b0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  nfa_number_format_arith DUT (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  task closeOut();
    $display("compares %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slowAns;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1)
        s_axi_bready <= 1'b1;
    end
    while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slowAns;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1)
        s_axi_rready <= 1'b1;
    end
    while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
    rdData = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one operation: configure, load, start, then read result and flags
  task run(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b,
           input logic [31:0] er, input logic [31:0] es);
    wr(nfa_pkg::ADDR_CTRL, c, 4'hf);
    wr(nfa_pkg::ADDR_OPA, a, 4'hf);
    wr(nfa_pkg::ADDR_OPB, b, 4'hf);
    wr(nfa_pkg::ADDR_CMD, 32'h1, 4'hf);
    rd(nfa_pkg::ADDR_RESULT);
    check("result", rdData, er);
    check("result rresp", {30'h0, rsp}, {30'h0, nfa_pkg::RESP_OKAY});
    rd(nfa_pkg::ADDR_STATUS);
    // integer mode only defines the zero and done flags
    check("status", rdData & (c[9] ? 32'h3f : 32'h30), es);
  endtask

  // hang guard: the sequence needs roughly 700 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    errCount++;
    closeOut();
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(nfa_pkg::ADDR_CTRL);
    check("ctrl reset", rdData, nfa_pkg::CTRL_RESET);
    wr(nfa_pkg::ADDR_CTRL, 32'hffff_ffff, 4'hf);
    rd(nfa_pkg::ADDR_CTRL);
    check("ctrl mask", rdData, 32'h0000_0fff);
    wr(nfa_pkg::ADDR_CTRL, 32'h0, 4'hf);
    wr(nfa_pkg::ADDR_CTRL, 32'h0000_ffff, 4'h2);
    rd(nfa_pkg::ADDR_CTRL);
    check("ctrl lane", rdData, 32'h0000_0f00);
    rd(nfa_pkg::ADDR_CMD);
    check("cmd read", rdData, 32'h0);
    wr(8'h1c, 32'h5a5a_5a5a, 4'hf);
    check("hole bresp", {30'h0, rsp}, {30'h0, nfa_pkg::RESP_SLVERR});
    rd(8'h1c);
    check("hole rresp", {30'h0, rsp}, {30'h0, nfa_pkg::RESP_SLVERR});
    // integer groups and formats
    run(32'h001, 32'hff, 32'h02, 32'hffff_fffe, 32'h20);
    run(32'h009, 32'hff, 32'h02, 32'h0000_01fe, 32'h20);
    run(32'h011, 32'h81, 32'h03, 32'hffff_fffd, 32'h20);
    run(32'h011, 32'h80, 32'h05, 32'h0, 32'h30);
    run(32'h000, 32'h1234_8000, 32'h1, 32'hffff_8000, 32'h20);
    run(32'h010, 32'hffff, 32'h1, 32'hffff_8001, 32'h20);
    run(32'h002, 32'h40, 32'h1, 32'hffff_ffc0, 32'h20);
    run(32'h013, 32'h3f, 32'h1, 32'hffff_ffe1, 32'h20);
    run(32'h004, 32'h8, 32'h7, 32'hffff_ffc8, 32'h20);
    run(32'h00d, 32'h7, 32'h7, 32'h31, 32'h20);
    run(32'h401, 32'hff, 32'h02, 32'h0000_0001, 32'h20);
    run(32'h801, 32'hff, 32'h02, 32'hffff_fffe, 32'h20);
    run(32'h005, 32'h4, 32'h1, 32'hffff_fffc, 32'h20);
    // result is read-only: write ignored but answered; answers held an edge
    slowAns = 1'b1;
    wr(nfa_pkg::ADDR_RESULT, 32'h1234_5678, 4'hf);
    check("ro bresp", {30'h0, rsp}, {30'h0, nfa_pkg::RESP_OKAY});
    rd(nfa_pkg::ADDR_RESULT);
    check("ro result", rdData, 32'hffff_fffc);
    slowAns = 1'b0;
    // float formats, specials, rounding
    run(32'h200, 32'h3fc000, 32'h400000, 32'h404000, 32'h20);
    run(32'h600, 32'h3fc000, 32'h400000, 32'h406000, 32'h20);
    run(32'h600, 32'h3fc000, 32'hbfc000, 32'h000000, 32'h30);
    run(32'h2a0, 32'h3e00, 32'h3e00, 32'h4080, 32'h20);
    run(32'h320, 32'h3e00, 32'h4000, 32'h4040, 32'h20);
    run(32'h240, 32'h3fc0, 32'h3fc0, 32'h401000, 32'h20);
    run(32'h200, 32'h8000ff, 32'h400000, 32'h800000, 32'h30);
    run(32'h200, 32'h7f80ff, 32'hc00000, 32'hff8000, 32'h28);
    run(32'h200, 32'h7f8000, 32'h000000, 32'h7f8000, 32'h2c);
    run(32'h200, 32'h718000, 32'h718000, 32'h7f8000, 32'h29);
    run(32'h200, 32'h0d8000, 32'h0d8000, 32'h000000, 32'h32);
    run(32'h280, 32'h3f8010, 32'h3f8000, 32'h3c00, 32'h20);
    run(32'h280, 32'h3f8030, 32'h3f8000, 32'h3c02, 32'h20);
    run(32'h280, 32'h3f8011, 32'h3f8000, 32'h3c01, 32'h20);
    run(32'h280, 32'h478000, 32'h3f8000, 32'h7c00, 32'h29);
    // accumulate keeps wide precision, output rounded again
    wr(nfa_pkg::ADDR_CMD, 32'h2, 4'hf);
    run(32'ha80, 32'h3f8001, 32'h3f8000, 32'h3c00, 32'h20);
    wr(nfa_pkg::ADDR_CMD, 32'h1, 4'hf);
    rd(nfa_pkg::ADDR_RESULT);
    check("mac result", rdData, 32'h4000);
    rd(nfa_pkg::ADDR_ACC);
    check("mac acc", rdData, 32'h400001);
    // clear wins over start
    wr(nfa_pkg::ADDR_CMD, 32'h3, 4'hf);
    rd(nfa_pkg::ADDR_ACC);
    check("acc clear", rdData, 32'h0);
    closeOut();
  end
endmodule
